// ---- hdl/msc3_pkg.sv ----
// Package with addresses, field layouts, reset values and scaling for the mode-3 bank.
package msc3_pkg;

  // Register addresses on the internal register port.
  localparam logic [7:0] MSC3_ADDR_PART1 = 8'h2F;
  localparam logic [7:0] MSC3_ADDR_PART2 = 8'h30;
  localparam logic [7:0] MSC3_ADDR_PART3 = 8'h31;

  // Reset values of the three registers.
  localparam logic [7:0] MSC3_RST_PART1 = 8'h4C;
  localparam logic [7:0] MSC3_RST_PART2 = 8'h4F;
  localparam logic [7:0] MSC3_RST_PART3 = 8'h0C;

  // Part 1 field positions.
  localparam int MSC3_P1_RESERVED_BIT_BIT   = 7;
  localparam int MSC3_P1_KEYCFG_BIT = 6;
  localparam int MSC3_P1_OFFS_BIT   = 5;
  localparam int MSC3_P1_CODE_MSB   = 4;
  // Part 2 field positions.
  localparam int MSC3_P2_AON_MSB    = 7;
  localparam int MSC3_P2_AON_LSB    = 4;
  localparam int MSC3_P2_CORE_EN    = 3;
  localparam int MSC3_P2_SYS_EN     = 2;
  localparam int MSC3_P2_AON_EN     = 1;
  localparam int MSC3_P2_LIN_EN     = 0;
  // Part 3 field positions.
  localparam int MSC3_P3_WD_MSB     = 7;
  localparam int MSC3_P3_WD_LSB     = 6;
  localparam int MSC3_P3_OFFS_BIT   = 5;
  localparam int MSC3_P3_CODE_MSB   = 4;

  // Mode number that this bank belongs to, and the fallback mode.
  localparam logic [1:0] MSC3_MODE_THIS = 2'h3;
  localparam logic [1:0] MSC3_MODE_ZERO = 2'h0;

  // Voltage scaling in millivolts.
  localparam logic [11:0] MSC3_MV_STEP      = 12'h019;
  localparam logic [11:0] MSC3_MV_OFFSET    = 12'h4B0;
  localparam logic [11:0] MSC3_MV_BASE_SYS  = 12'h5DC;
  localparam logic [11:0] MSC3_MV_BASE_AON  = 12'h6A4;
  localparam logic [4:0]  MSC3_CODE_TOP_SYS = 5'h18;
  localparam logic [3:0]  MSC3_CODE_TOP_AON = 4'h8;

  // Watchdog period encoding and value in seconds.
  localparam logic [1:0] MSC3_WD_OFF = 2'h0;
  localparam logic [1:0] MSC3_WD_16  = 2'h1;
  localparam logic [1:0] MSC3_WD_32  = 2'h2;
  localparam logic [6:0] MSC3_WD_S16 = 7'h10;
  localparam logic [6:0] MSC3_WD_S32 = 7'h20;
  localparam logic [6:0] MSC3_WD_S64 = 7'h40;

  // Settings applied to the analog side while mode 3 is active.
  typedef struct packed {
    logic        core_buck_en;
    logic        system_buck_en;
    logic        always_on_en;
    logic        system_linear_en;
    logic [11:0] system_buck_mv;
    logic [11:0] always_on_mv;
    logic [11:0] system_linear_mv;
    logic [6:0]  watchdog_s;
  } msc3_rail_cfg_t;

endpackage : msc3_pkg

// ---- hdl/msc3_pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module msc3_pin_sync #(
  parameter int          WIDTH    = 1,
  parameter logic [15:0] RST_LEVEL = 16'h0000
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Pins and clean levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

  always_comb begin
    s1_nxt  = pin_in;
    s2_nxt  = s1_r;
    s3_nxt  = s2_r;
    // A bit follows stage two only where stages two and three agree.
    lvl_nxt = (lvl_r & (s2_r ^ s3_r)) | (s2_r & ~(s2_r ^ s3_r));
    if (!resetn) begin
      s1_nxt  = RST_LEVEL[WIDTH-1:0];
      s2_nxt  = RST_LEVEL[WIDTH-1:0];
      s3_nxt  = RST_LEVEL[WIDTH-1:0];
      lvl_nxt = RST_LEVEL[WIDTH-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    s1_r  <= s1_nxt;
    s2_r  <= s2_nxt;
    s3_r  <= s3_nxt;
    lvl_r <= lvl_nxt;
  end

  assign level_out = lvl_r;

endmodule : msc3_pin_sync

// ---- hdl/msc3_config_bank.sv ----
// Mode-setting-3 configuration bank: three registers, mode selection and applied settings.
`timescale 1ns/1ns
module msc3_config_bank
  import msc3_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           resetn,
  // Register port from the serial target
  input  wire logic [7:0]     reg_addr,
  input  wire logic           reg_wr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_rd,
  output logic      [7:0]     reg_rdata,
  output logic                reg_hit,
  // Mode selection sources
  input  wire logic           pin_mode_pick_m3,
  input  wire logic           mode_pick_bit_low,
  input  wire logic           mode_pick_bit_high,
  input  wire logic           mode_pick_pin_low,
  input  wire logic           mode_pick_pin_high,
  // Power key pin, idle high
  input  wire logic           power_key_pin,
  // Mode status and settings to the power stage
  output logic      [1:0]     active_mode,
  output logic                mode3_active,
  output logic                mode0_switch_req,
  output msc3_rail_cfg_t      rail_cfg
);

  // Clean pin levels: bit 2 key, bits 1:0 mode pins.
  // The key stage resets to its idle high level so that leaving reset never reads as a press.
  localparam int          PIN_WIDTH = 3;
  localparam int          PIN_KEY   = 2;
  localparam logic [15:0] PIN_RST   = 16'h0004;

  logic [PIN_WIDTH-1:0] pin_lvl;

  msc3_pin_sync #(
    .WIDTH     (PIN_WIDTH),
    .RST_LEVEL (PIN_RST)
  ) u_pin_sync (
    .mclk      (mclk),
    .resetn    (resetn),
    .pin_in    ({power_key_pin, mode_pick_pin_high, mode_pick_pin_low}),
    .level_out (pin_lvl)
  );

  // Register file.
  logic [7:0] part1_r, part2_r, part3_r, rdata_r;
  logic [7:0] part1_nxt, part2_nxt, part3_nxt, rdata_nxt;
  logic       hit_r, hit_nxt;

  always_comb begin
    part1_nxt = part1_r;
    part2_nxt = part2_r;
    part3_nxt = part3_r;
    rdata_nxt = rdata_r;
    hit_nxt   = 1'b0;
    if (reg_wr) begin
      // Every bit, the reserved one included, is stored as written.
      case (reg_addr)
        MSC3_ADDR_PART1: part1_nxt = reg_wdata;
        MSC3_ADDR_PART2: part2_nxt = reg_wdata;
        MSC3_ADDR_PART3: part3_nxt = reg_wdata;
        default: ;
      endcase
    end
    // A read in the same cycle as a write to that address returns the old value.
    if (reg_rd) begin
      hit_nxt = 1'b1;
      case (reg_addr)
        MSC3_ADDR_PART1: rdata_nxt = part1_r;
        MSC3_ADDR_PART2: rdata_nxt = part2_r;
        MSC3_ADDR_PART3: rdata_nxt = part3_r;
        default: begin
          rdata_nxt = 8'h00;
          hit_nxt   = 1'b0;
        end
      endcase
    end
    if (!resetn) begin
      part1_nxt = MSC3_RST_PART1;
      part2_nxt = MSC3_RST_PART2;
      part3_nxt = MSC3_RST_PART3;
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    part1_r <= part1_nxt;
    part2_r <= part2_nxt;
    part3_r <= part3_nxt;
    rdata_r <= rdata_nxt;
    hit_r   <= hit_nxt;
  end

  assign reg_rdata = rdata_r;
  assign reg_hit   = hit_r;

  // Field views.
  logic       key_cfg;
  logic       sys_offs, lin_offs;
  logic [4:0] sys_code, lin_code;
  logic [3:0] aon_code;
  logic [1:0] wd_code;

  assign key_cfg  = part1_r[MSC3_P1_KEYCFG_BIT];
  assign sys_offs = part1_r[MSC3_P1_OFFS_BIT];
  assign sys_code = part1_r[MSC3_P1_CODE_MSB:0];
  assign aon_code = part2_r[MSC3_P2_AON_MSB:MSC3_P2_AON_LSB];
  assign wd_code  = part3_r[MSC3_P3_WD_MSB:MSC3_P3_WD_LSB];
  assign lin_offs = part3_r[MSC3_P3_OFFS_BIT];
  assign lin_code = part3_r[MSC3_P3_CODE_MSB:0];

  // Five-bit code to millivolts, saturating at the top code, plus optional offset.
  function automatic logic [11:0] code5_mv(input logic [4:0] code, input logic offs);
    logic [4:0]  sat;
    logic [11:0] mv;
    sat = (code > MSC3_CODE_TOP_SYS) ? MSC3_CODE_TOP_SYS : code;
    mv  = MSC3_MV_BASE_SYS + 12'(MSC3_MV_STEP * {7'h00, sat});
    if (offs) begin
      mv = mv + MSC3_MV_OFFSET;
    end
    return mv;
  endfunction : code5_mv

  // Four-bit always-on code to millivolts, saturating at the top code.
  function automatic logic [11:0] code4_mv(input logic [3:0] code);
    logic [3:0] sat;
    sat = (code > MSC3_CODE_TOP_AON) ? MSC3_CODE_TOP_AON : code;
    return MSC3_MV_BASE_AON + 12'(MSC3_MV_STEP * {8'h00, sat});
  endfunction : code4_mv

  // Watchdog code to seconds; zero leaves the watchdog off.
  function automatic logic [6:0] wd_seconds(input logic [1:0] code);
    logic [6:0] s;
    case (code)
      MSC3_WD_OFF: s = 7'h00;
      MSC3_WD_16:  s = MSC3_WD_S16;
      MSC3_WD_32:  s = MSC3_WD_S32;
      default:     s = MSC3_WD_S64;
    endcase
    return s;
  endfunction : wd_seconds

  // Mode selection and applied settings.
  logic [1:0]     mode_sel;
  logic           key_fall;
  logic [1:0]     mode_r, mode_nxt;
  logic           key_d_r, key_d_nxt;
  logic           sw0_r, sw0_nxt;
  logic           m3_r, m3_nxt;
  msc3_rail_cfg_t cfg_r, cfg_nxt;

  // The unused source is ignored entirely.
  assign mode_sel = pin_mode_pick_m3 ? pin_lvl[1:0]
                                     : {mode_pick_bit_high, mode_pick_bit_low};
  assign key_fall = key_d_r & ~pin_lvl[PIN_KEY];

  always_comb begin
    mode_nxt  = mode_sel;
    key_d_nxt = pin_lvl[PIN_KEY];
    sw0_nxt   = 1'b0;
    cfg_nxt   = '0;
    // The request is only meaningful in mode 3, so it is raised only for a key fall seen while mode 3 is active.
    if ((mode_r == MSC3_MODE_THIS) && key_fall && !key_cfg) begin
      sw0_nxt = 1'b1;
    end
    // Settings fall to zero outside mode 3 so the power stage never sees stale values.
    if (mode_r == MSC3_MODE_THIS) begin
      cfg_nxt.core_buck_en     = part2_r[MSC3_P2_CORE_EN];
      cfg_nxt.system_buck_en   = part2_r[MSC3_P2_SYS_EN];
      cfg_nxt.always_on_en     = part2_r[MSC3_P2_AON_EN];
      cfg_nxt.system_linear_en = part2_r[MSC3_P2_LIN_EN];
      cfg_nxt.system_buck_mv   = code5_mv(sys_code, sys_offs);
      cfg_nxt.always_on_mv     = code4_mv(aon_code);
      cfg_nxt.system_linear_mv = code5_mv(lin_code, lin_offs);
      cfg_nxt.watchdog_s       = wd_seconds(wd_code);
    end
    if (!resetn) begin
      mode_nxt  = MSC3_MODE_ZERO;
      key_d_nxt = 1'b1;
      sw0_nxt   = 1'b0;
      cfg_nxt   = '0;
    end
    // Registered so that the mode flag is a flop output and not a decode of one.
    m3_nxt = (mode_nxt == MSC3_MODE_THIS);
  end

  always_ff @(posedge mclk) begin
    mode_r  <= mode_nxt;
    key_d_r <= key_d_nxt;
    sw0_r   <= sw0_nxt;
    cfg_r   <= cfg_nxt;
    m3_r    <= m3_nxt;
  end

  assign active_mode      = mode_r;
  assign mode3_active     = m3_r;
  assign mode0_switch_req = sw0_r;
  assign rail_cfg         = cfg_r;

endmodule : msc3_config_bank

// ---- testbench/msc3_bank_asserts.sv ----
// Port checker for the mode-3 configuration bank.
`timescale 1ns/1ns
module msc3_bank_asserts
  import msc3_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           resetn,
  // Register port
  input wire logic [7:0]     reg_addr,
  input wire logic           reg_rd,
  input wire logic [7:0]     reg_rdata,
  input wire logic           reg_hit,
  // Mode and settings
  input wire logic           pin_mode_pick_m3,
  input wire logic           mode_pick_bit_low,
  input wire logic           mode_pick_bit_high,
  input wire logic [1:0]     active_mode,
  input wire logic           mode3_active,
  input wire logic           mode0_switch_req,
  input wire msc3_rail_cfg_t rail_cfg
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic mapped;
  assign mapped = reg_addr inside {MSC3_ADDR_PART1, MSC3_ADDR_PART2, MSC3_ADDR_PART3};
  sequence s_rd_hit;
    reg_rd && mapped;
  endsequence
  sequence s_rd_miss;
    reg_rd && !mapped;
  endsequence
  chk_rd_hit: assert property (s_rd_hit |=> reg_hit)
    else $error("mapped read not flagged");
  chk_rd_miss: assert property (s_rd_miss |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  chk_hit_pulse: assert property (!reg_rd |=> !reg_hit)
    else $error("hit without read");
  chk_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  chk_mode_decode: assert property (mode3_active == (active_mode == MSC3_MODE_THIS))
    else $error("mode 3 flag wrong");
  chk_rail_idle: assert property (!mode3_active |=> rail_cfg == '0)
    else $error("settings applied outside mode 3");
  chk_req_pulse: assert property (mode0_switch_req |=> !mode0_switch_req)
    else $error("switch request longer than one cycle");
  chk_req_mode: assert property (mode0_switch_req |-> $past(mode3_active))
    else $error("switch request outside mode 3");
  chk_bits_pick: assert property ($past(resetn) && !$past(pin_mode_pick_m3) |->
    active_mode == {$past(mode_pick_bit_high), $past(mode_pick_bit_low)})
    else $error("mode not taken from register bits");
endmodule : msc3_bank_asserts

bind msc3_config_bank msc3_bank_asserts i_msc3_bank_asserts (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .pin_mode_pick_m3(pin_mode_pick_m3),
  .mode_pick_bit_low(mode_pick_bit_low), .mode_pick_bit_high(mode_pick_bit_high),
  .active_mode(active_mode), .mode3_active(mode3_active),
  .mode0_switch_req(mode0_switch_req), .rail_cfg(rail_cfg));

// ---- testbench/msc3_host_model.sv ----
// Host model that issues single register reads and writes.
`timescale 1ns/1ns
module msc3_host_model (
  // Clock
  input wire logic       mclk,
  // Register port
  output logic [7:0]     reg_addr,
  output logic           reg_wr,
  output logic [7:0]     reg_wdata,
  output logic           reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit
);
  initial begin
    reg_addr = 8'hD0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle address and data are inverted so a stale value never looks current.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask : rd
endmodule : msc3_host_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the mode-3 configuration bank.
`timescale 1ns/1ns
module tb_top;
  import msc3_pkg::*;
  logic           mclk = 1'b0;
  logic           resetn = 1'b0;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata;
  logic           reg_wr, reg_rd, reg_hit;
  logic           pin_mode_pick_m3 = 1'b0;
  logic           mode_pick_bit_low = 1'b0;
  logic           mode_pick_bit_high = 1'b0;
  logic           mode_pick_pin_low = 1'b0;
  logic           mode_pick_pin_high = 1'b0;
  logic           power_key_pin = 1'b1;
  logic [1:0]     active_mode;
  logic           mode3_active, mode0_switch_req;
  msc3_rail_cfg_t rail_cfg;
  int             miscompares = 0;
  int             n_checks = 0;
  int             regs [3] = '{8'h4C, 8'h4F, 8'h0C};

  always #50 mclk = ~mclk;

  msc3_host_model i_msc3_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  msc3_config_bank i_msc3_config_bank (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .pin_mode_pick_m3(pin_mode_pick_m3),
    .mode_pick_bit_low(mode_pick_bit_low), .mode_pick_bit_high(mode_pick_bit_high),
    .mode_pick_pin_low(mode_pick_pin_low), .mode_pick_pin_high(mode_pick_pin_high),
    .power_key_pin(power_key_pin), .active_mode(active_mode), .mode3_active(mode3_active),
    .mode0_switch_req(mode0_switch_req), .rail_cfg(rail_cfg));

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic int mv(input int code, input int off, input int base, input int top);
    return base + 25 * (code > top ? top : code) + 1200 * off;
  endfunction : mv
  task automatic rd_chk(input int i);
    logic [7:0] d;
    logic       h;
    i_msc3_host_model.rd(8'h2F + 8'(i), d, h);
    chk("register", {h, d}, {1'b1, 8'(regs[i])});
  endtask : rd_chk
  task automatic wait_mode(input logic [1:0] m);
    int k;
    for (k = 0; k < 20 && active_mode !== m; k++) @(negedge mclk);
    chk("active_mode", active_mode, m);
    chk("mode3_active", mode3_active, m == MSC3_MODE_THIS);
    if (k == 20) end_sim();
  endtask : wait_mode
  // The key is held low long enough to pass the synchroniser before release.
  task automatic key(input int exp);
    int n;
    n = 0;
    power_key_pin = 1'b0;
    repeat (12) begin
      @(negedge mclk);
      n += int'(mode0_switch_req === 1'b1);
    end
    power_key_pin = 1'b1;
    repeat (8) @(negedge mclk);
    chk("switch pulses", n, exp);
  endtask : key

  initial begin
    repeat (20000) @(negedge mclk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [7:0]  d;
    logic        h;
    msc3_rail_cfg_t exp;
    void'($urandom(32'hE5C635D1));
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 3; i++) rd_chk(i);
    repeat (4) begin
      for (int i = 0; i < 3; i++) begin
        regs[i] = $urandom & 8'hFF;
        i_msc3_host_model.wr(8'h2F + 8'(i), 8'(regs[i]));
      end
      for (int i = 0; i < 3; i++) rd_chk(i);
    end
    i_msc3_host_model.wr(8'h32, 8'h5A);
    i_msc3_host_model.rd(8'h2E, d, h);
    chk("unmapped", {h, d}, 9'h000);
    for (int i = 0; i < 3; i++) rd_chk(i);
    chk("rail mode 0", rail_cfg, '0);
    mode_pick_bit_low = 1'b1;
    mode_pick_bit_high = 1'b1;
    wait_mode(2'h3);
    for (int c = 0; c < 32; c++) begin
      regs[0] = ($urandom & 8'hA0) | 8'h40 | c;
      regs[1] = ((c & 15) << 4) | (c & 15);
      regs[2] = ((c & 3) << 6) | ($urandom & 8'h20) | (31 - c);
      for (int i = 0; i < 3; i++) i_msc3_host_model.wr(8'h2F + 8'(i), 8'(regs[i]));
      repeat (2) @(negedge mclk);
      exp = {4'(regs[1]), 12'(mv(regs[0] & 31, regs[0] >> 5 & 1, 1500, 24)),
        12'(mv(regs[1] >> 4, 0, 1700, 8)), 12'(mv(regs[2] & 31, regs[2] >> 5 & 1, 1500, 24)),
        7'((regs[2] >> 6) ? 8 << (regs[2] >> 6) : 0)};
      chk("rail_cfg", rail_cfg, exp);
    end
    key(0);
    i_msc3_host_model.wr(8'h2F, 8'h0C);
    key(1);
    pin_mode_pick_m3 = 1'b1;
    wait_mode(2'h0);
    key(0);
    mode_pick_pin_low = 1'b1;
    mode_pick_pin_high = 1'b1;
    mode_pick_bit_high = 1'b0;
    wait_mode(2'h3);
    key(1);
    end_sim();
  end
endmodule : tb_top
